//--- common/ocp_consts.vh
// constants for the output compare / pwm block (two channels)
`ifndef OCP_CONSTS_VH
`define OCP_CONSTS_VH

// register byte addresses (16-bit registers on a 16-bit data path)
`define OCP_ADDR_W        9
`define OCP_A_CH1_SEC     9'h180
`define OCP_A_CH1_MAIN    9'h182
`define OCP_A_CH1_CTRL    9'h184
`define OCP_A_CH2_SEC     9'h186
`define OCP_A_CH2_MAIN    9'h188
`define OCP_A_CH2_CTRL    9'h18A
`define OCP_A_TMR_FLAGS   9'h190
`define OCP_A_TMR_CLR     9'h192

// control register fields
`define OCP_MODE_HI       2
`define OCP_MODE_LO       0
`define OCP_TSEL_BIT      3
`define OCP_FLT_BIT       4
`define OCP_SIDL_BIT      13
`define OCP_CTRL_MASK     16'h201F
`define OCP_CTRL_RESET    16'h0000
`define OCP_REG_RESET     16'h0000
`define OCP_DUTY_ZERO     16'h0000

// mode codes
`define OCP_M_OFF         3'h0
`define OCP_M_LOW         3'h1
`define OCP_M_HIGH        3'h2
`define OCP_M_TOGGLE      3'h3
`define OCP_M_SINGLE      3'h4
`define OCP_M_CONT        3'h5
`define OCP_M_PWM         3'h6
`define OCP_M_PWMF        3'h7

// timer flag register bits
`define OCP_TFA_BIT       0
`define OCP_TFB_BIT       1

`endif

//--- rtl/ocp_channel_pair.v
// two output compare / pwm channels with register port and timer inputs
// Behaviour
// - modes 1,2,3: match forces low, high, toggles
// - single-edge compares main value to selected timer
// - timer wrap before match leaves pin alone
// - mode 4 single pulse, mode 5 continuous
// - main match sets pin, secondary clears
// - one pulse per write of mode 4
// - continuous pulse repeats each timer period
// - modes 6,7 pwm; main becomes read-only latch
// - mode 7 fault low tristates the pin
// - fault sets status bit 4
// - fault held until cleared and mode rewritten
// - period is timer period plus one
// - period rollover sets pin, loads duty, flags timer
// - zero duty keeps pin low
// - duty above period keeps pin high
// - sleep freezes pin level, resumes after
// - idle runs only when no stop bits set
// - modes 1-5 main match sets compare flag, also secondary in 5 and armed 4; sw clears
// - pwm never sets compare flag; timer flag instead
// - control layout mode,select,fault,idle; rest zero
// - select clear uses timer a, set timer b
//
// Decided for this implementation: strobed register access.
`timescale 1ns/1ps
`include "ocp_consts.vh"

module ocp_channel_pair (
   input  wire                    CLK_I,
   input  wire                    RST_I,
   input  wire [`OCP_ADDR_W-1:0]  ADDR_I,
   input  wire [15:0]             WDATA_I,
   input  wire                    WR_I,
   input  wire                    RD_I,
   output reg  [15:0]             RDATA_O,
   input  wire [15:0]             TMRA_COUNT_I,
   input  wire [15:0]             TMRA_PERIOD_I,
   input  wire                    TMRA_RUN_I,
   input  wire                    TMRA_IDLE_STOP_I,
   input  wire                    TMRA_TICK_I,
   input  wire [15:0]             TMRB_COUNT_I,
   input  wire [15:0]             TMRB_PERIOD_I,
   input  wire                    TMRB_RUN_I,
   input  wire                    TMRB_IDLE_STOP_I,
   input  wire                    TMRB_TICK_I,
   input  wire                    IDLE_I,
   input  wire                    SLEEP_I,
   input  wire [1:0]              FAULT_N_I,
   input  wire [1:0]              CMP_IRQ_EN_I,
   output reg  [1:0]              CMP_IRQ_FLAG_O,
   output wire [1:0]              CMP_IRQ_O,
   output reg  [1:0]              PIN_O,
   output reg  [1:0]              PIN_OE_N_O
);

// ---------------------------------------------------------------
// pin synchronisers
// ---------------------------------------------------------------
// TMRA_TICK_I / TMRB_TICK_I mark the increment cycle: the cycle in which the timer
// advances from its current count (wrap to zero after a period match).
reg  [1:0]  flt_meta;
reg  [1:0]  flt_sync;
reg         idle_meta;
reg         idle_sync;
reg         sleep_meta;
reg         sleep_sync;

always @(posedge CLK_I or posedge RST_I) begin
   if (RST_I) begin
      flt_meta   <= 2'h3;
      flt_sync   <= 2'h3;
      idle_meta  <= 1'b0;
      idle_sync  <= 1'b0;
      sleep_meta <= 1'b0;
      sleep_sync <= 1'b0;
   end else begin
      flt_meta   <= FAULT_N_I;
      flt_sync   <= flt_meta;
      idle_meta  <= IDLE_I;
      idle_sync  <= idle_meta;
      sleep_meta <= SLEEP_I;
      sleep_sync <= sleep_meta;
   end
end

// ---------------------------------------------------------------
// register storage
// ---------------------------------------------------------------
reg  [15:0] sec_val [0:1];
reg  [15:0] main_val [0:1];
reg  [15:0] ctrl [0:1];
reg  [1:0]  pulse_done;
reg  [1:0]  tmr_flag;

function [1:0] reg_sel;
   input [`OCP_ADDR_W-1:0] a;
   begin
      if (a == `OCP_A_CH1_SEC || a == `OCP_A_CH2_SEC)
         reg_sel = 2'h1;
      else if (a == `OCP_A_CH1_MAIN || a == `OCP_A_CH2_MAIN)
         reg_sel = 2'h2;
      else if (a == `OCP_A_CH1_CTRL || a == `OCP_A_CH2_CTRL)
         reg_sel = 2'h3;
      else
         reg_sel = 2'h0;
   end
endfunction

function chan_of;
   input [`OCP_ADDR_W-1:0] a;
   begin
      chan_of = (a == `OCP_A_CH2_SEC) || (a == `OCP_A_CH2_MAIN) || (a == `OCP_A_CH2_CTRL);
   end
endfunction

wire [1:0] wsel = reg_sel(ADDR_I);
wire       wch  = chan_of(ADDR_I);

// per-channel evaluation
reg  [1:0]  run;
reg  [1:0]  tick;
reg  [1:0]  ev_main;
reg  [1:0]  ev_sec;
reg  [1:0]  pwm_roll;
reg  [1:0]  pwm_mode;
reg  [1:0]  ctrl_wr;
reg  [15:0] cnt [0:1];
reg  [15:0] per [0:1];
reg  [1:0]  pwm_flag;
integer     k;

always @* begin
   pwm_flag = 2'h0;
   for (k = 0; k < 2; k = k + 1) begin
      // timer a by default, b when selected
      cnt[k]  = ctrl[k][`OCP_TSEL_BIT] ? TMRB_COUNT_I : TMRA_COUNT_I;
      per[k]  = ctrl[k][`OCP_TSEL_BIT] ? TMRB_PERIOD_I : TMRA_PERIOD_I;
      tick[k] = ctrl[k][`OCP_TSEL_BIT] ? TMRB_TICK_I : TMRA_TICK_I;
      // idle keeps running only with no stop bit set; sleep freezes every match and rollover event
      run[k]  = !sleep_sync &&
                (!idle_sync || (!ctrl[k][`OCP_SIDL_BIT] &&
                 (ctrl[k][`OCP_TSEL_BIT] ? (TMRB_RUN_I && !TMRB_IDLE_STOP_I)
                                         : (TMRA_RUN_I && !TMRA_IDLE_STOP_I))));
      pwm_mode[k] = ctrl[k][`OCP_MODE_HI] && ctrl[k][`OCP_MODE_HI-1];
      ctrl_wr[k]  = WR_I && wsel == 2'h3 && wch == k[0];
      // match is taken when the counter holds the value on its increment cycle;
      // a wrap short of the value therefore never produces an event
      ev_main[k]  = run[k] && tick[k] && cnt[k] == main_val[k];
      ev_sec[k]   = run[k] && tick[k] && cnt[k] == sec_val[k];
      pwm_roll[k] = run[k] && tick[k] && cnt[k] == per[k] && pwm_mode[k];
      if (pwm_roll[k])
         pwm_flag[ctrl[k][`OCP_TSEL_BIT]] = 1'b1;
   end
end

// ---------------------------------------------------------------
// next-state decode per channel
// ---------------------------------------------------------------
// pin and pulse decisions are made here so that PIN_O and pulse_done have one
// simple update; flag and drive-enable priority sit with their own registers
reg  [1:0]  next_pin;
reg  [1:0]  next_done;
reg  [1:0]  flt_trip;
reg  [1:0]  flag_set;
reg  [1:0]  flag_clr;
reg  [1:0]  duty_fall;
reg  [2:0]  md;
integer     j;

always @* begin
   next_pin  = PIN_O;
   next_done = pulse_done;
   flt_trip  = 2'h0;
   flag_set  = 2'h0;
   flag_clr  = 2'h0;
   duty_fall = 2'h0;
   md        = `OCP_M_OFF;
   for (j = 0; j < 2; j = j + 1) begin
      md = ctrl[j][`OCP_MODE_HI:`OCP_MODE_LO];
      // a rewrite of the single-pulse mode re-arms; a same-cycle end of
      // pulse below still wins
      if (ctrl_wr[j] && WDATA_I[2:0] == `OCP_M_SINGLE)
         next_done[j] = 1'b0;
      // a duty above the period never matches, so the pin stays high
      duty_fall[j] = run[j] && tick[j] && cnt[j] == main_val[j] &&
                     main_val[j] <= per[j];
      case (md)
         `OCP_M_OFF: begin
            next_pin[j] = PIN_O[j];
         end
         `OCP_M_LOW: begin
            if (ev_main[j])
               next_pin[j] = 1'b0;
         end
         `OCP_M_HIGH: begin
            if (ev_main[j])
               next_pin[j] = 1'b1;
         end
         `OCP_M_TOGGLE: begin
            if (ev_main[j])
               next_pin[j] = ~PIN_O[j];
         end
         `OCP_M_SINGLE: begin
            if (ev_sec[j] && !pulse_done[j]) begin
               next_pin[j]  = 1'b0;
               next_done[j] = 1'b1;
            end else if (ev_main[j] && !pulse_done[j]) begin
               next_pin[j] = 1'b1;
            end
         end
         `OCP_M_CONT: begin
            if (ev_sec[j])
               next_pin[j] = 1'b0;
            else if (ev_main[j])
               next_pin[j] = 1'b1;
         end
         default: begin
            if (pwm_roll[j]) begin
               if (sec_val[j] == `OCP_DUTY_ZERO)
                  next_pin[j] = 1'b0;
               else
                  next_pin[j] = 1'b1;
            end else if (duty_fall[j]) begin
               next_pin[j] = 1'b0;
            end
            // sleep stops the clocks, so a fault is not acted on then
            if (md == `OCP_M_PWMF && !flt_sync[j] && !sleep_sync)
               flt_trip[j] = 1'b1;
         end
      endcase
      if (!pwm_mode[j] && md != `OCP_M_OFF &&
          (ev_main[j] || (md[`OCP_MODE_HI] && ev_sec[j] &&
           !(md[`OCP_MODE_LO] == 1'b0 && pulse_done[j]))))
         flag_set[j] = 1'b1;
      if (WR_I && ADDR_I == `OCP_A_TMR_CLR && WDATA_I[j+2])
         flag_clr[j] = 1'b1;
   end
end

// ---------------------------------------------------------------
// register storage updates
// ---------------------------------------------------------------
integer i;
always @(posedge CLK_I or posedge RST_I) begin
   if (RST_I) begin
      for (i = 0; i < 2; i = i + 1) begin
         sec_val[i]  <= `OCP_REG_RESET;
         main_val[i] <= `OCP_REG_RESET;
         ctrl[i]     <= `OCP_CTRL_RESET;
      end
   end else begin
      for (i = 0; i < 2; i = i + 1) begin
         if (WR_I && wch == i[0] && wsel == 2'h1)
            sec_val[i] <= WDATA_I;
         // main value is a read-only duty latch in pwm
         if (WR_I && wch == i[0] && wsel == 2'h2 && !pwm_mode[i])
            main_val[i] <= WDATA_I;
         else if (pwm_roll[i])
            main_val[i] <= sec_val[i];
         if (ctrl_wr[i]) begin
            // fault flag is hardware-owned; a write cannot set it
            ctrl[i] <= (WDATA_I & `OCP_CTRL_MASK & ~(16'h0001 << `OCP_FLT_BIT)) |
                       (ctrl[i] & (16'h0001 << `OCP_FLT_BIT) &
                        {16{!flt_sync[i] && WDATA_I[2:0] == `OCP_M_PWMF}});
         end
         if (flt_trip[i])
            ctrl[i][`OCP_FLT_BIT] <= 1'b1;
      end
   end
end

// ---------------------------------------------------------------
// pin level and pulse arming
// ---------------------------------------------------------------
always @(posedge CLK_I or posedge RST_I) begin
   if (RST_I) begin
      pulse_done <= 2'h0;
      PIN_O      <= 2'h0;
   end else begin
      pulse_done <= next_done;
      PIN_O      <= next_pin;
   end
end

// ---------------------------------------------------------------
// pin drive enable
// ---------------------------------------------------------------
// a trip wins over a same-cycle rewrite, so the pin never glitches back
// on while the fault level is still present
integer n;
always @(posedge CLK_I or posedge RST_I) begin
   if (RST_I) begin
      PIN_OE_N_O <= 2'h0;
   end else begin
      for (n = 0; n < 2; n = n + 1) begin
         if (flt_trip[n])
            PIN_OE_N_O[n] <= 1'b1;
         else if (ctrl_wr[n] && (WDATA_I[2:0] != `OCP_M_PWMF || flt_sync[n]))
            PIN_OE_N_O[n] <= 1'b0;
      end
   end
end

// ---------------------------------------------------------------
// compare flags
// ---------------------------------------------------------------
// set wins over a same-cycle write-one clear
always @(posedge CLK_I or posedge RST_I) begin
   if (RST_I) begin
      CMP_IRQ_FLAG_O <= 2'h0;
   end else begin
      CMP_IRQ_FLAG_O <= flag_set | (CMP_IRQ_FLAG_O & ~flag_clr);
   end
end

assign CMP_IRQ_O = CMP_IRQ_FLAG_O & CMP_IRQ_EN_I;

// ---------------------------------------------------------------
// timer period flags
// ---------------------------------------------------------------
always @(posedge CLK_I or posedge RST_I) begin
   if (RST_I) begin
      tmr_flag <= 2'h0;
   end else begin
      // set wins over a same-cycle write-one clear
      tmr_flag <= pwm_flag |
                  (tmr_flag & ~({2{WR_I && ADDR_I == `OCP_A_TMR_CLR}} & WDATA_I[1:0]));
   end
end

// ---------------------------------------------------------------
// read port
// ---------------------------------------------------------------
// read data stand for one cycle only and are zero otherwise
reg  [15:0] next_rdata;

always @* begin
   next_rdata = 16'h0000;
   if (RD_I) begin
      if (wsel == 2'h1)
         next_rdata = sec_val[wch];
      else if (wsel == 2'h2)
         next_rdata = main_val[wch];
      else if (wsel == 2'h3)
         next_rdata = ctrl[wch] & `OCP_CTRL_MASK;
      else if (ADDR_I == `OCP_A_TMR_FLAGS)
         next_rdata = {12'h000, CMP_IRQ_FLAG_O, tmr_flag};
      else
         next_rdata = 16'h0000;
   end
end

always @(posedge CLK_I or posedge RST_I) begin
   if (RST_I) begin
      RDATA_O <= 16'h0000;
   end else begin
      RDATA_O <= next_rdata;
   end
end

endmodule // ocp_channel_pair

//--- testbench/ocp_chk_assertions.sv
// concurrent checks on the ports of the channel pair; mode, pin and fault checks for channel 1, irq gate for both
`timescale 1ns/1ps
`include "ocp_consts.vh"
module ocp_chk (
   input wire                   CLK_I,
   input wire                   RST_I,
   input wire [`OCP_ADDR_W-1:0] ADDR_I,
   input wire [15:0]            WDATA_I,
   input wire                   WR_I,
   input wire                   RD_I,
   input wire [15:0]            RDATA_O,
   input wire [1:0]             FAULT_N_I,
   input wire [1:0]             CMP_IRQ_EN_I,
   input wire [1:0]             CMP_IRQ_FLAG_O,
   input wire [1:0]             CMP_IRQ_O,
   input wire [1:0]             PIN_O,
   input wire [1:0]             PIN_OE_N_O
);
   reg  [2:0] mode;
   wire       cw = WR_I && (ADDR_I == `OCP_A_CH1_CTRL);
   default clocking @(posedge CLK_I); endclocking
   default disable iff (RST_I);
   // shadow of the channel 1 mode, so rules can be tied to the mode
   always @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) mode <= 3'h0;
      else if (cw) mode <= WDATA_I[2:0];
   end
   rd_idle_zero_a: assert property (!$past(RD_I) |-> RDATA_O == 16'h0000)
      else $error("read data not zero outside read cycle");
   ctrl_unused_a: assert property ($past(RD_I && ADDR_I == `OCP_A_CH1_CTRL)
      |-> (RDATA_O & ~`OCP_CTRL_MASK) == 16'h0000) else $error("unused control bits set");
   irq_gate_a: assert property (CMP_IRQ_O == (CMP_IRQ_FLAG_O & CMP_IRQ_EN_I))
      else $error("irq not flag and enable");
   force_low_a: assert property (mode == `OCP_M_LOW && !cw && !PIN_O[0] |=> !PIN_O[0])
      else $error("pin rose in force low mode");
   force_high_a: assert property (mode == `OCP_M_HIGH && !cw && PIN_O[0] |=> PIN_O[0])
      else $error("pin fell in force high mode");
   off_stable_a: assert property (mode == `OCP_M_OFF && !cw |=> $stable(PIN_O[0]))
      else $error("pin moved while channel off");
   pwm_no_flag_a: assert property (mode[2:1] == 2'b11 && !cw && !CMP_IRQ_FLAG_O[0]
      |=> !CMP_IRQ_FLAG_O[0]) else $error("compare flag set in pwm");
   fault_trip_a: assert property (mode == `OCP_M_PWMF && !cw && $fell(FAULT_N_I[0])
      |-> ##[1:4] PIN_OE_N_O[0]) else $error("fault did not release pin");
   fault_hold_a: assert property (PIN_OE_N_O[0] && !cw |=> PIN_OE_N_O[0])
      else $error("faulted pin released without write");
   drive_on_a: assert property (mode != `OCP_M_PWMF && !cw |=> !PIN_OE_N_O[0])
      else $error("pin released outside fault mode");
endmodule // ocp_chk

//--- testbench/ocp_load.sv
// far-side model: load on the compare pins and the fault inputs
`timescale 1ns/1ps
module ocp_load (
   input  wire [1:0] pin_i,
   input  wire [1:0] oe_n_i,
   input  wire [1:0] fault_req_i,
   output wire [1:0] fault_n_o,
   output reg  [1:0] pad_o
);
   reg [1:0] last = 2'b00;
   integer   k;
   assign fault_n_o = ~fault_req_i;
   // no pull on the pad, so a released pin shows the inverse of its last level
   always @* begin
      for (k = 0; k < 2; k = k + 1) begin
         if (!oe_n_i[k]) begin
            last[k]  = pin_i[k];
            pad_o[k] = pin_i[k];
         end else pad_o[k] = ~last[k];
      end
   end
endmodule // ocp_load

//--- testbench/tb_top.sv
// self-checking bench for the channel pair
`timescale 1ns/1ps
`include "ocp_consts.vh"
module tb_top;
   reg         clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0;
   reg  [8:0]  addr = 9'h000;
   reg  [15:0] wd = 16'h0000, ca = 16'h0000, cb = 16'h0000, pa = 16'h0009, pb = 16'h0003;
   reg         run = 1'b0, idle = 1'b0, slp = 1'b0, tidl = 1'b0, p;
   reg  [1:0]  flt = 2'b00, ien = 2'b11;
   reg  [15:0] d, e, hc;
   wire [15:0] rdata;
   wire [1:0]  fn, cf, ci, pin, oen, pad;
   integer     mismatches = 0, checks = 0, i;
   always #4 clk = ~clk;
   // timer model: the count wraps to zero after it equals the period
   always @(posedge clk) if (run) begin
      ca <= (ca == pa) ? 16'h0000 : ca + 16'h0001;
      cb <= (cb == pb) ? 16'h0000 : cb + 16'h0001;
   end
   ocp_channel_pair i_dut (.CLK_I(clk), .RST_I(rst), .ADDR_I(addr), .WDATA_I(wd),
      .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .TMRA_COUNT_I(ca), .TMRA_PERIOD_I(pa),
      .TMRA_RUN_I(run), .TMRA_IDLE_STOP_I(tidl), .TMRA_TICK_I(run), .TMRB_COUNT_I(cb),
      .TMRB_PERIOD_I(pb), .TMRB_RUN_I(run), .TMRB_IDLE_STOP_I(1'b0), .TMRB_TICK_I(run),
      .IDLE_I(idle), .SLEEP_I(slp), .FAULT_N_I(fn), .CMP_IRQ_EN_I(ien),
      .CMP_IRQ_FLAG_O(cf), .CMP_IRQ_O(ci), .PIN_O(pin), .PIN_OE_N_O(oen));
   ocp_load i_load (.pin_i(pin), .oe_n_i(oen), .fault_req_i(flt), .fault_n_o(fn),
      .pad_o(pad));
   // ---------------------------------------------------------------
   // access and compare tasks
   // ---------------------------------------------------------------
   task cyc(input integer n); begin repeat (n) @(posedge clk); #1; end endtask
   // counts the cycles in which channel 1 pin is high
   task hcnt(input integer n);
      begin
         hc = 16'h0000;
         repeat (n) begin cyc(1); hc = hc + pin[0]; end
      end
   endtask
   task chk(input [15:0] seen, input [15:0] exp, input string nm);
      begin
         checks = checks + 1;
         if (seen !== exp) begin
            mismatches = mismatches + 1;
            $display("MISMATCH %0s expected %h seen %h", nm, exp, seen);
         end
      end
   endtask
   task wreg(input [8:0] a, input [15:0] v);
      begin
         @(posedge clk); addr <= a; wd <= v; wr <= 1'b1;
         @(posedge clk); wr <= 1'b0;
      end
   endtask
   task rchk(input [8:0] a, input [15:0] exp, input string nm);
      begin
         @(posedge clk); addr <= a; rd <= 1'b1;
         @(posedge clk); rd <= 1'b0;
         #1 chk(rdata, exp, nm);
      end
   endtask
   task summarize;
      begin
         $display("checks %0d mismatches %0d", checks, mismatches);
         if (mismatches == 0 && checks > 0) $display("ALL CHECKS OK");
         else $display("CHECKS NOT OK");
         $finish;
      end
   endtask
   initial begin #200000; mismatches = mismatches + 1; summarize; end
   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   initial begin
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      for (i = 0; i < 6; i = i + 1) rchk(9'h180 + 2 * i, 16'h0000, "reset");
      rchk(9'h1FE, 16'h0000, "unmapped");
      wreg(`OCP_A_CH2_CTRL, 16'hFFFF);
      rchk(`OCP_A_CH2_CTRL, 16'h200F, "ctrl2");
      wreg(`OCP_A_CH2_CTRL, 16'h0000);
      wreg(`OCP_A_CH1_MAIN, 16'h0005);
      run <= 1'b1;
      wreg(`OCP_A_CH1_CTRL, 16'h0002); cyc(12);
      chk(pin[0], 1'b1, "force high");
      chk(pad[0], 1'b1, "pad driven");
      chk(ci[0], 1'b1, "irq");
      wreg(`OCP_A_CH1_CTRL, 16'h0001); cyc(12);
      chk(pin[0], 1'b0, "force low");
      wreg(`OCP_A_CH1_CTRL, 16'h0003); cyc(11);
      chk(pin[0], 1'b1, "toggle 1");
      cyc(10); chk(pin[0], 1'b0, "toggle 2");
      wreg(`OCP_A_CH1_CTRL, 16'h0000);
      wreg(`OCP_A_TMR_CLR, 16'h000F); cyc(20);
      chk(cf[0], 1'b0, "flag clear");
      chk(pin[0], 1'b0, "off pin");
      // timer b wraps at 3, below main, so the pin must not move
      wreg(`OCP_A_CH1_CTRL, 16'h000A); cyc(20);
      chk(pin[0], 1'b0, "wrap");
      // dual compare: rise at 2, fall at 6, period 9 not below 6
      wreg(`OCP_A_CH1_MAIN, 16'h0002);
      wreg(`OCP_A_CH1_SEC, 16'h0006);
      wreg(`OCP_A_CH1_CTRL, 16'h0005); cyc(25); hcnt(10);
      chk(hc, 16'h0004, "cont pulse");
      wreg(`OCP_A_CH1_CTRL, 16'h0004); cyc(25); hcnt(10);
      chk(hc, 16'h0000, "pulse done");
      wreg(`OCP_A_TMR_CLR, 16'h000F);
      wreg(`OCP_A_CH1_CTRL, 16'h0004); hcnt(20);
      chk(hc, 16'h0004, "one pulse");
      chk(cf[0], 1'b1, "pulse flag");
      wreg(`OCP_A_CH1_CTRL, 16'h0003);
      for (i = 0; i < 2; i = i + 1) begin
         if (i == 0) slp <= 1'b1; else begin idle <= 1'b1; tidl <= 1'b1; end
         cyc(3); p = pin[0]; cyc(30);
         chk(pin[0], p, "frozen");
         slp <= 1'b0; idle <= 1'b0; tidl <= 1'b0;
         cyc(1);
      end
      wreg(`OCP_A_CH1_CTRL, 16'h0006);
      wreg(`OCP_A_TMR_CLR, 16'h000F);
      for (i = 0; i < 3; i = i + 1) begin
         d = (i == 0) ? 16'h0004 : (i == 1) ? 16'h0000 : 16'h000A;
         e = (i == 0) ? 16'h0005 : (i == 1) ? 16'h0000 : 16'h000A;
         wreg(`OCP_A_CH1_SEC, d); cyc(25); hcnt(10);
         chk(hc, e, "duty");
         rchk(`OCP_A_CH1_MAIN, d, "latch");
      end
      wreg(`OCP_A_CH1_MAIN, 16'h0007);
      rchk(`OCP_A_CH1_MAIN, 16'h000A, "main ro");
      chk(cf[0], 1'b0, "pwm flag");
      rchk(`OCP_A_TMR_FLAGS, 16'h0001, "tmr flag");
      wreg(`OCP_A_CH1_CTRL, 16'h0007);
      flt <= 2'b01; cyc(6);
      chk(oen[0], 1'b1, "fault hiz");
      rchk(`OCP_A_CH1_CTRL, 16'h0017, "fault bit");
      flt <= 2'b00; cyc(6);
      chk(oen[0], 1'b1, "fault held");
      wreg(`OCP_A_CH1_CTRL, 16'h0007); cyc(2);
      chk(oen[0], 1'b0, "fault off");
      rchk(`OCP_A_CH1_CTRL, 16'h0007, "fault clr");
      summarize;
   end
endmodule // tb_top
bind ocp_channel_pair ocp_chk u_chk (.CLK_I(CLK_I), .RST_I(RST_I), .ADDR_I(ADDR_I),
   .WDATA_I(WDATA_I), .WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O), .FAULT_N_I(FAULT_N_I),
   .CMP_IRQ_EN_I(CMP_IRQ_EN_I), .CMP_IRQ_FLAG_O(CMP_IRQ_FLAG_O), .CMP_IRQ_O(CMP_IRQ_O),
   .PIN_O(PIN_O), .PIN_OE_N_O(PIN_OE_N_O));
